/* File: logic/gsr_consts.svh */
// How it works
// - Activation status echoes the activation command: 0 reset, 1 activated.
// - Mode status echoes requested grasp mode: basic, pinch, wide, scissor.
// - Go-to status echoes the go-to command bit.
// - State field: 0 reset/release, 1 activating, 2 mode change, 3 ready.
// - Motion: 0 moving, 1 some fingers short, 2 all short, 3 all reached.
// - Each axis contact code: 0 moving, 1 opening stop, 2 closing stop, 3 arrived.
// - Contact stop holds until opposite request, more force, or go-to re-armed.
// - Fault 0 none; 5, 6, 7 flag actions before activation or mode done.
// - Minor faults 9, A, B light the fault LED steadily.
// - Major faults D, E, F blink the fault LED and need a reset.
// - Scissor interference reports A, then E once it outlasts the limit.
// - Major faults clear only by dropping activation; raising it again recalibrates.
// - Echo A returns finger A or common position request.
// - Echo bytes return requested positions for B, C and scissor.
// - Position bytes return each axis's measured position.
// - Current bytes return each axis's motor current count.
// - Bytes pair into 16-bit words from 0x07D0, lower byte in upper half.
// - Bank refreshes at 100 Hz; controller spaces commands 10 ms apart.
`ifndef GSR_CONSTS_SVH
`define GSR_CONSTS_SVH
`define GSR_NUM_BYTES     15
`define GSR_OFS_GRIP      4'h0
`define GSR_OFS_CONTACT   4'h1
`define GSR_OFS_FAULT     4'h2
`define GSR_OFS_ECHO_A    4'h3
`define GSR_OFS_POS_A     4'h4
`define GSR_OFS_LOAD_A    4'h5
`define GSR_AXIS_STRIDE   4'h3
`define GSR_ACT_BIT       0
`define GSR_MODE_LSB      1
`define GSR_GOTO_BIT      3
`define GSR_STATE_LSB     4
`define GSR_MOTION_LSB    6
`define GSR_WORD_BASE     16'h07D0
`define GSR_WORD_COUNT    16'h0008
`define GSR_CT_MOVING     2'h0
`define GSR_CT_STOP_OPEN  2'h1
`define GSR_CT_STOP_CLOSE 2'h2
`define GSR_CT_AT_TARGET  2'h3
`define GSR_MO_MOVING     2'h0
`define GSR_MO_SOME_SHORT 2'h1
`define GSR_MO_ALL_SHORT  2'h2
`define GSR_MO_REACHED    2'h3
`define GSR_F_NONE        4'h0
`define GSR_F_ACT_BUSY    4'h5
`define GSR_F_MODE_BUSY   4'h6
`define GSR_F_NO_ACT      4'h7
`define GSR_F_COMM        4'h9
`define GSR_F_INTERF      4'hA
`define GSR_F_RELEASING   4'hB
`define GSR_F_ACT_FAIL    4'hD
`define GSR_F_INTERF_LONG 4'hE
`define GSR_F_RELEASED    4'hF
`define GSR_F_MINOR_MIN   4'h9
`define GSR_F_MAJOR_MIN   4'hD
`define GSR_CLK_PERIOD_NS 10
`define GSR_REFRESH_NS    10000000
`define GSR_INTERF_MS     20000
`endif

/* File: logic/gsr_pkg.sv */
package gsr_pkg;
  typedef enum logic [2:0] {GS_RESET, GS_ACT, GS_MODE, GS_READY, GS_MAJOR} gsr_phase_t;

  typedef struct packed {
    gsr_phase_t       phase;
    logic [1:0]       mode_cur;
    logic [3:0]       major_code;
    logic [31:0]      interf_cnt;
    logic             goto_prev;
    logic [3:0][1:0]  contact;
    logic [3:0][7:0]  tgt_prev;
    logic [3:0][7:0]  stop_force;
    logic             rd_pend;
    logic             rd_err;
    logic             rd_valid;
  } gsr_state_t;
endpackage : gsr_pkg

/* File: logic/gsr_tick_div.sv */
`timescale 1ns/1ps
module gsr_tick_div #(
  parameter int unsigned DIV = 1000000
) (
  input  wire logic mclk_i,  // System clock
  input  wire logic rst_i,   // Synchronous reset
  output logic      tick_o   // One-cycle enable every DIV cycles
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } gsr_div_t;

  gsr_div_t s_r;
  gsr_div_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt == 32'(DIV - 1)) begin
      s_nxt.cnt = 32'h0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_o = s_r.tick;
endmodule : gsr_tick_div

/* File: logic/gsr_status_mem.sv */
`timescale 1ns/1ps
module gsr_status_mem #(
  parameter int unsigned DEPTH = 15
) (
  input  wire logic                   mclk_i,   // System clock
  input  wire logic                   rst_i,    // Synchronous reset
  input  wire logic                   load_i,   // Capture a full snapshot
  input  wire logic [DEPTH-1:0][7:0]  wdata_i,  // Snapshot bytes, index = byte
  input  wire logic                   rd_en_i,  // Fetch one word
  input  wire logic [2:0]             word_i,   // Word index
  output logic      [15:0]            rdata_o   // Registered word
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [15:0]           rdata;
  } gsr_mem_t;

  gsr_mem_t s_r;
  gsr_mem_t s_nxt;
  logic [DEPTH:0][7:0]   padded;

  // Odd byte count: the last word's low half reads zero
  assign padded = {8'h00, s_r.mem};

  always_comb begin
    s_nxt = s_r;
    if (load_i) begin
      s_nxt.mem = wdata_i;
    end
    if (rd_en_i) begin
      s_nxt.rdata = {padded[{word_i, 1'b0}], padded[{word_i, 1'b1}]};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o = s_r.rdata;
endmodule : gsr_status_mem

/* File: logic/gsr_bank.sv */
`timescale 1ns/1ps
`include "gsr_consts.svh"
module gsr_bank import gsr_pkg::*; #(
  parameter int unsigned REFRESH_CYCLES = `GSR_REFRESH_NS / `GSR_CLK_PERIOD_NS,
  parameter int unsigned INTERF_CYCLES  =
    32'(64'(`GSR_INTERF_MS) * 64'd1000000 / 64'(`GSR_CLK_PERIOD_NS))
) (
  input  wire logic             mclk_i,               // 100 MHz clock
  input  wire logic             rst_i,                // Synchronous reset
  input  wire logic             activation_command_i, // Commanded activation
  input  wire logic [1:0]       grasp_mode_command_i, // Requested grasp mode
  input  wire logic             goto_command_i,       // Commanded go-to
  input  wire logic             indiv_finger_i,       // Individual finger control
  input  wire logic             indiv_scissor_i,      // Individual scissor control
  input  wire logic [7:0]       target_cmd_a_i,       // Finger A / common request
  input  wire logic [7:0]       target_cmd_b_i,       // Finger B request
  input  wire logic [7:0]       target_cmd_c_i,       // Finger C request
  input  wire logic [7:0]       target_cmd_scissor_i, // Scissor request
  input  wire logic [3:0][7:0]  force_cmd_i,          // Force per axis A,B,C,S
  input  wire logic [3:0][7:0]  actual_pos_i,         // Measured position per axis
  input  wire logic [3:0][7:0]  motor_load_i,         // Current count per axis
  input  wire logic [3:0]       contact_det_i,        // Current limit hit per axis
  input  wire logic             calib_done_i,         // Activation motion finished
  input  wire logic             calib_fail_i,         // Activation motion failed
  input  wire logic             mode_done_i,          // Mode change finished
  input  wire logic             scissor_interf_i,     // Scissor blocked in mode change
  input  wire logic             autorel_active_i,     // Automatic release running
  input  wire logic             autorel_done_i,       // Automatic release finished
  input  wire logic             comm_ready_i,         // Comms chip ready
  input  wire logic             rd_req_i,             // Word read strobe
  input  wire logic [15:0]      rd_addr_i,            // Word address
  output logic      [15:0]      rd_data_o,            // Read word
  output logic                  rd_valid_o,           // Read answer pulse
  output logic                  rd_err_o,             // Address out of range
  output logic      [3:0]       axis_run_o,           // Axis may move
  output logic      [3:0][7:0]  axis_target_o,        // Effective target per axis
  output logic                  calib_run_o,          // Run activation motion
  output logic                  mode_run_o,           // Run mode change
  output logic                  fault_led_steady_o,   // Fault LED steady red
  output logic                  fault_led_blink_o     // Fault LED blinking red
);
  gsr_state_t s_r;
  gsr_state_t s_nxt;

  logic                    tick;
  logic [3:0][7:0]         tgt;
  logic [3:0][1:0]         contact_nxt;
  logic [3:0]              release_stop;
  logic                    goto_rise;
  logic                    armed;
  logic [3:0]              fault_code_w;
  logic [1:0]              state_field;
  logic [1:0]              motion;
  logic [1:0]              short_cnt;
  logic [`GSR_NUM_BYTES-1:0][7:0] snap;
  logic                    addr_ok;
  logic [15:0]             word_ofs;
  logic                    interf_over;

  gsr_tick_div #(
    .DIV (REFRESH_CYCLES)
  ) u_div (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  // Fingers B and C follow the common request unless driven individually
  assign tgt[0] = target_cmd_a_i;
  assign tgt[1] = indiv_finger_i ? target_cmd_b_i : target_cmd_a_i;
  assign tgt[2] = indiv_finger_i ? target_cmd_c_i : target_cmd_a_i;
  assign tgt[3] = target_cmd_scissor_i;
  assign axis_target_o = tgt;

  assign goto_rise = goto_command_i & ~s_r.goto_prev;
  assign armed = goto_command_i & (s_r.phase == GS_READY);

  for (genvar i = 0; i < 4; i++) begin : g_axis
    logic closing;
    logic stopped;
    assign closing = tgt[i] > actual_pos_i[i];
    assign stopped = (s_r.contact[i] == `GSR_CT_STOP_OPEN) ||
                     (s_r.contact[i] == `GSR_CT_STOP_CLOSE);
    assign release_stop[i] = goto_rise ||
        (force_cmd_i[i] > s_r.stop_force[i]) ||
        ((tgt[i] != s_r.tgt_prev[i]) &&
         (closing != (s_r.contact[i] == `GSR_CT_STOP_CLOSE)));

    always_comb begin
      contact_nxt[i] = s_r.contact[i];
      if (stopped) begin
        if (release_stop[i]) begin
          contact_nxt[i] = `GSR_CT_MOVING;
        end
      end else if (armed) begin
        if (contact_det_i[i]) begin
          contact_nxt[i] = closing ? `GSR_CT_STOP_CLOSE : `GSR_CT_STOP_OPEN;
        end else if (actual_pos_i[i] == tgt[i]) begin
          contact_nxt[i] = `GSR_CT_AT_TARGET;
        end else begin
          contact_nxt[i] = `GSR_CT_MOVING;
        end
      end
    end

    assign axis_run_o[i] = armed && (s_r.contact[i] == `GSR_CT_MOVING);

    a_contact_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
      stopped && !release_stop[i] |=> $stable(s_r.contact[i]))
      else $error("contact stop released without cause");
    a_contact_stop: assert property (@(posedge mclk_i) disable iff (rst_i)
      !stopped && armed && contact_det_i[i] && closing
      |=> s_r.contact[i] == `GSR_CT_STOP_CLOSE ##1 !axis_run_o[i] || !goto_command_i)
      else $error("closing contact did not stop axis");
  end

  assign interf_over = s_r.interf_cnt >= INTERF_CYCLES;

  always_comb begin
    s_nxt = s_r;
    s_nxt.goto_prev = goto_command_i;
    s_nxt.contact = contact_nxt;
    s_nxt.rd_valid = s_r.rd_pend;
    s_nxt.rd_pend = 1'b0;
    for (int k = 0; k < 4; k++) begin
      s_nxt.tgt_prev[k] = tgt[k];
      if (contact_nxt[k] != s_r.contact[k] && contact_nxt[k] != `GSR_CT_MOVING &&
          contact_nxt[k] != `GSR_CT_AT_TARGET) begin
        s_nxt.stop_force[k] = force_cmd_i[k];
      end
    end
    s_nxt.interf_cnt = (s_r.phase == GS_MODE && scissor_interf_i) ?
                       s_r.interf_cnt + 32'h1 : 32'h0;
    case (s_r.phase)
      GS_RESET: begin
        if (activation_command_i) begin
          s_nxt.phase = GS_ACT;
        end
      end
      GS_ACT: begin
        if (calib_fail_i) begin
          s_nxt.phase = GS_MAJOR;
          s_nxt.major_code = `GSR_F_ACT_FAIL;
        end else if (calib_done_i) begin
          s_nxt.phase = GS_READY;
          s_nxt.mode_cur = grasp_mode_command_i;
        end
      end
      GS_READY: begin
        if (!indiv_scissor_i && grasp_mode_command_i != s_r.mode_cur) begin
          s_nxt.phase = GS_MODE;
        end
      end
      GS_MODE: begin
        if (interf_over) begin
          s_nxt.phase = GS_MAJOR;
          s_nxt.major_code = `GSR_F_INTERF_LONG;
        end else if (mode_done_i) begin
          s_nxt.phase = GS_READY;
          s_nxt.mode_cur = grasp_mode_command_i;
        end
      end
      GS_MAJOR: begin
        s_nxt.phase = GS_MAJOR;
      end
      default: begin
        s_nxt.phase = GS_RESET;
      end
    endcase
    if (autorel_done_i && s_r.phase != GS_RESET && s_r.phase != GS_MAJOR) begin
      s_nxt.phase = GS_MAJOR;
      s_nxt.major_code = `GSR_F_RELEASED;
    end
    // Dropping activation is the only way out of a major fault
    if (!activation_command_i) begin
      s_nxt.phase = GS_RESET;
      s_nxt.major_code = `GSR_F_NONE;
    end
    if (rd_req_i) begin
      s_nxt.rd_pend = 1'b1;
      s_nxt.rd_err = !addr_ok;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Majors outrank minors, minors outrank the action-refused codes
  always_comb begin
    fault_code_w = `GSR_F_NONE;
    if (s_r.phase == GS_MAJOR) begin
      fault_code_w = s_r.major_code;
    end else if (autorel_active_i) begin
      fault_code_w = `GSR_F_RELEASING;
    end else if (s_r.phase == GS_MODE && scissor_interf_i) begin
      fault_code_w = `GSR_F_INTERF;
    end else if (!comm_ready_i) begin
      fault_code_w = `GSR_F_COMM;
    end else if (goto_command_i && !activation_command_i) begin
      fault_code_w = `GSR_F_NO_ACT;
    end else if (goto_command_i && s_r.phase == GS_ACT) begin
      fault_code_w = `GSR_F_ACT_BUSY;
    end else if (goto_command_i && s_r.phase == GS_MODE) begin
      fault_code_w = `GSR_F_MODE_BUSY;
    end
  end

  assign fault_led_blink_o = fault_code_w >= `GSR_F_MAJOR_MIN;
  assign fault_led_steady_o = fault_code_w >= `GSR_F_MINOR_MIN &&
                              fault_code_w < `GSR_F_MAJOR_MIN;
  assign calib_run_o = s_r.phase == GS_ACT;
  assign mode_run_o = s_r.phase == GS_MODE;

  always_comb begin
    case (s_r.phase)
      GS_ACT:   state_field = 2'h1;
      GS_MODE:  state_field = 2'h2;
      GS_READY: state_field = autorel_active_i ? 2'h0 : 2'h3;
      default:  state_field = 2'h0;
    endcase
  end

  // Motion summary covers the three fingers; scissor has its own contact code
  always_comb begin
    short_cnt = 2'h0;
    for (int k = 0; k < 3; k++) begin
      if (s_r.contact[k] == `GSR_CT_STOP_OPEN || s_r.contact[k] == `GSR_CT_STOP_CLOSE) begin
        short_cnt = short_cnt + 2'h1;
      end
    end
    if (s_r.contact[0] == `GSR_CT_MOVING || s_r.contact[1] == `GSR_CT_MOVING ||
        s_r.contact[2] == `GSR_CT_MOVING) begin
      motion = `GSR_MO_MOVING;
    end else if (short_cnt == 2'h0) begin
      motion = `GSR_MO_REACHED;
    end else if (short_cnt == 2'h3) begin
      motion = `GSR_MO_ALL_SHORT;
    end else begin
      motion = `GSR_MO_SOME_SHORT;
    end
  end

  always_comb begin
    snap = '0;
    snap[`GSR_OFS_GRIP][`GSR_ACT_BIT] = activation_command_i;
    snap[`GSR_OFS_GRIP][`GSR_MODE_LSB +: 2] = grasp_mode_command_i;
    snap[`GSR_OFS_GRIP][`GSR_GOTO_BIT] = goto_command_i;
    snap[`GSR_OFS_GRIP][`GSR_STATE_LSB +: 2] = state_field;
    snap[`GSR_OFS_GRIP][`GSR_MOTION_LSB +: 2] = motion;
    snap[`GSR_OFS_CONTACT] = s_r.contact;
    snap[`GSR_OFS_FAULT] = {4'h0, fault_code_w};
    snap[`GSR_OFS_ECHO_A] = target_cmd_a_i;
    snap[`GSR_OFS_ECHO_A + `GSR_AXIS_STRIDE] = target_cmd_b_i;
    snap[`GSR_OFS_ECHO_A + 2 * `GSR_AXIS_STRIDE] = target_cmd_c_i;
    snap[`GSR_OFS_ECHO_A + 3 * `GSR_AXIS_STRIDE] = target_cmd_scissor_i;
    for (int k = 0; k < 4; k++) begin
      snap[4'(`GSR_OFS_POS_A + k * `GSR_AXIS_STRIDE)] = actual_pos_i[k];
      snap[4'(`GSR_OFS_LOAD_A + k * `GSR_AXIS_STRIDE)] = motor_load_i[k];
    end
  end

  assign word_ofs = rd_addr_i - `GSR_WORD_BASE;
  assign addr_ok = rd_addr_i >= `GSR_WORD_BASE && word_ofs < `GSR_WORD_COUNT;

  logic [15:0] mem_word;

  // Readers see the last 10 ms snapshot, never a half-updated set
  gsr_status_mem #(
    .DEPTH (`GSR_NUM_BYTES)
  ) u_mem (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .load_i  (tick),
    .wdata_i (snap),
    .rd_en_i (rd_req_i && addr_ok),
    .word_i  (word_ofs[2:0]),
    .rdata_o (mem_word)
  );

  assign rd_valid_o = s_r.rd_valid;
  assign rd_err_o = s_r.rd_valid && s_r.rd_err;
  assign rd_data_o = (s_r.rd_valid && !s_r.rd_err) ? mem_word : 16'h0000;

  sequence s_major_held;
    s_r.phase == GS_MAJOR && !activation_command_i;
  endsequence
  sequence s_rearm;
    s_r.phase == GS_RESET && activation_command_i;
  endsequence

  a_major_latch: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_r.phase == GS_MAJOR && activation_command_i |=> s_r.phase == GS_MAJOR)
    else $error("major fault left without reset");
  a_recal_path: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_major_held ##1 s_rearm |=> s_r.phase == GS_ACT && calib_run_o)
    else $error("reactivation did not recalibrate");
  a_interf_escalate: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_r.phase == GS_MODE && interf_over && activation_command_i && !autorel_done_i
    |=> fault_code_w == `GSR_F_INTERF_LONG && fault_led_blink_o)
    else $error("interference did not escalate");
  a_interf_minor: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_r.phase == GS_MODE && scissor_interf_i && !autorel_active_i
    |-> fault_code_w == `GSR_F_INTERF && fault_led_steady_o)
    else $error("short interference not minor");
  a_led_exclusive: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(fault_led_steady_o && fault_led_blink_o) &&
    (fault_code_w != `GSR_F_NONE || (!fault_led_steady_o && !fault_led_blink_o)))
    else $error("fault LED state wrong");
  a_no_act_fault: assert property (@(posedge mclk_i) disable iff (rst_i)
    goto_command_i && !activation_command_i && comm_ready_i && !autorel_active_i
    && s_r.phase != GS_MAJOR && !(s_r.phase == GS_MODE && scissor_interf_i)
    |-> fault_code_w == `GSR_F_NO_ACT ##1 !activation_command_i |-> s_r.phase == GS_RESET)
    else $error("missing activation fault");
  a_read_answer: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_req_i && !addr_ok |-> ##2 rd_valid_o && rd_err_o && rd_data_o == 16'h0000)
    else $error("bad address answered wrongly");
  a_state_ready: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_r.phase == GS_ACT && calib_done_i && !calib_fail_i && activation_command_i
    && !autorel_done_i && !autorel_active_i |=> state_field == 2'h3 || mode_run_o)
    else $error("activation completion not reported");
endmodule : gsr_bank

/* File: testbench/gsr_ctrl_model.sv */
`timescale 1ns/1ps
module gsr_ctrl_model (
  input  wire logic        mclk_i,     // System clock
  output logic             rd_req_o,   // Word read strobe
  output logic      [15:0] rd_addr_o,  // Word address
  input  wire logic [15:0] rd_data_i,  // Read word
  input  wire logic        rd_valid_i, // Answer pulse
  input  wire logic        rd_err_i    // Address error
);
  initial begin
    rd_req_o = 1'b0;
    rd_addr_o = 16'h0000;
  end
  // Polls one word; the strobe spans exactly one rising edge
  task automatic read(input logic [15:0] addr, output logic [15:0] data, output logic [1:0] st);
    @(negedge mclk_i);
    rd_req_o = 1'b1;
    rd_addr_o = addr;
    @(negedge mclk_i);
    rd_req_o = 1'b0;
    // Idle address flips to the complement of the read address so a stale value can never be mistaken for a request
    rd_addr_o = ~addr;
    // Answer stands for one full cycle, so the falling edge sees it settled
    @(negedge mclk_i);
    data = rd_data_i;
    st = {rd_valid_i, rd_err_i};
  endtask : read
endmodule : gsr_ctrl_model

/* File: testbench/gsr_bank_tb.sv */
`timescale 1ns/1ps
module gsr_bank_tb;
  import gsr_pkg::*;
  localparam int RF = 16;
  logic            mclk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            act = 0, gto = 0, ifg = 0, isc = 0;
  logic [1:0]      mode = 2'h0;
  logic [3:0][7:0] t = '0, frc = '0, pos = '0, ld = '0;
  logic [3:0]      cdet = '0;
  logic            cdone = 0, cfail = 0, mdone = 0, sint = 0, activation_command = 0, rdone = 0, crdy = 1;
  logic            rq, rv, re, crun, mrun, lst, lbl;
  logic [15:0]     ra, rd, got;
  logic [1:0]      st;
  logic [3:0]      run;
  logic [3:0][7:0] atg;
  int              bad_count = 0;
  int              comparisons = 0;

  always #5 mclk_i = ~mclk_i;

  gsr_bank #(.REFRESH_CYCLES(RF), .INTERF_CYCLES(20)) i_gsr_bank (
    .mclk_i(mclk_i), .rst_i(rst_i), .activation_command_i(act),
    .grasp_mode_command_i(mode), .goto_command_i(gto), .indiv_finger_i(ifg),
    .indiv_scissor_i(isc), .target_cmd_a_i(t[0]), .target_cmd_b_i(t[1]),
    .target_cmd_c_i(t[2]), .target_cmd_scissor_i(t[3]), .force_cmd_i(frc),
    .actual_pos_i(pos), .motor_load_i(ld), .contact_det_i(cdet),
    .calib_done_i(cdone), .calib_fail_i(cfail), .mode_done_i(mdone),
    .scissor_interf_i(sint), .autorel_active_i(activation_command), .autorel_done_i(rdone),
    .comm_ready_i(crdy), .rd_req_i(rq), .rd_addr_i(ra), .rd_data_o(rd),
    .rd_valid_o(rv), .rd_err_o(re), .axis_run_o(run), .axis_target_o(atg),
    .calib_run_o(crun), .mode_run_o(mrun), .fault_led_steady_o(lst),
    .fault_led_blink_o(lbl)
  );

  gsr_ctrl_model i_gsr_ctrl_model (
    .mclk_i(mclk_i), .rd_req_o(rq), .rd_addr_o(ra), .rd_data_i(rd),
    .rd_valid_i(rv), .rd_err_i(re)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rdw(input logic [15:0] addr, input logic [15:0] exp, input logic err);
    i_gsr_ctrl_model.read(addr, got, st);
    check(got, exp);
    check(16'(st), {14'h0, 1'b1, err});
  endtask : rdw

  // Two refresh periods so the snapshot surely holds the live values
  task automatic settle();
    repeat (2 * RF + 8) @(negedge mclk_i);
  endtask : settle

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : cyc

  task automatic t_reset();
    rdw(16'h07D0, 16'h0000, 1'b0);
    rdw(16'h07D8, 16'h0000, 1'b1);
    rdw(16'h07CF, 16'h0000, 1'b1);
  endtask : t_reset

  task automatic t_activate();
    act = 1;
    mode = 2'h2;
    cyc(2);
    check(16'(crun), 16'h0001);
    settle();
    rdw(16'h07D0, 16'h1500, 1'b0);
    cdone = 1;
    cyc(1);
    cdone = 0;
    settle();
    rdw(16'h07D0, 16'h3500, 1'b0);
  endtask : t_activate

  task automatic t_data();
    logic [7:0] b [16];
    t = 32'h4410F080;
    pos = 32'h44902080;
    ld = 32'h0F5AA5FF;
    cyc(1);
    check(16'(atg[1]), 16'h0080);
    ifg = 1;
    cyc(1);
    check(16'(atg[1]), 16'h00F0);
    settle();
    b[2] = 8'h00;
    b[15] = 8'h00;
    for (int k = 0; k < 4; k++) begin
      b[3 + 3 * k] = t[k];
      b[4 + 3 * k] = pos[k];
      b[5 + 3 * k] = ld[k];
    end
    for (int n = 1; n < 8; n++) begin
      rdw(16'h07D0 + 16'(n), {b[2 * n], b[2 * n + 1]}, 1'b0);
    end
  endtask : t_data

  task automatic t_contact();
    cdet = 4'b0110;
    gto = 1;
    cyc(3);
    check(16'(run), 16'h0000);
    settle();
    rdw(16'h07D0, 16'h7DDB, 1'b0);
    cdet = 4'b0000;
    settle();
    rdw(16'h07D0, 16'h7DDB, 1'b0);
    frc[1] = 8'h10;
    cyc(3);
    check(16'(run), 16'h0002);
    settle();
    rdw(16'h07D0, 16'h3DD3, 1'b0);
    // One single re-arm of go-to, never a rapid toggle
    gto = 0;
    cyc(2);
    gto = 1;
    settle();
    rdw(16'h07D0, 16'h3DC3, 1'b0);
  endtask : t_contact

  task automatic t_faults();
    crdy = 0;
    cyc(3);
    check(16'({lst, lbl}), 16'h0002);
    settle();
    rdw(16'h07D1, 16'h0980, 1'b0);
    crdy = 1;
    activation_command = 1;
    settle();
    rdw(16'h07D1, 16'h0B80, 1'b0);
    activation_command = 0;
  endtask : t_faults

  task automatic t_mode();
    gto = 0;
    mode = 2'h3;
    cyc(3);
    check(16'(mrun), 16'h0001);
    gto = 1;
    settle();
    rdw(16'h07D1, 16'h0680, 1'b0);
    rdw(16'h07D0, 16'h2FC3, 1'b0);
    sint = 1;
    cyc(3);
    check(16'({lst, lbl}), 16'h0002);
    cyc(25);
    check(16'({lst, lbl}), 16'h0001);
    settle();
    rdw(16'h07D1, 16'h0E80, 1'b0);
  endtask : t_mode

  task automatic t_recover();
    act = 0;
    sint = 0;
    settle();
    rdw(16'h07D1, 16'h0780, 1'b0);
    act = 1;
    settle();
    rdw(16'h07D1, 16'h0580, 1'b0);
    cfail = 1;
    cyc(1);
    cfail = 0;
    settle();
    rdw(16'h07D1, 16'h0D80, 1'b0);
    // A one-cycle drop walks the shortest legal path out of a major fault
    act = 0;
    cyc(1);
    act = 1;
    cyc(2);
    cdone = 1;
    cyc(1);
    cdone = 0;
    settle();
    rdw(16'h07D1, 16'h0080, 1'b0);
    rdone = 1;
    cyc(1);
    rdone = 0;
    settle();
    rdw(16'h07D1, 16'h0F80, 1'b0);
  endtask : t_recover

  task automatic give_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (8) @(negedge mclk_i);
    rst_i = 0;
    t_reset();
    t_activate();
    t_data();
    t_contact();
    t_faults();
    t_mode();
    t_recover();
    give_verdict();
  end

  // Fixed waits only, so this limit trips only on a stuck run
  initial begin
    repeat (8000) @(posedge mclk_i);
    bad_count++;
    give_verdict();
  end
endmodule : gsr_bank_tb
